// *** hdl/wpc_sync.sv ***
`timescale 1ns/100ps
module wpc_sync #(
  parameter logic RESET_VAL = 1'h0
) (
  input wire logic i_clk, // Destination clock
  input wire logic i_nrst, // Synchronous reset, active low
  input wire logic i_d, // Asynchronous level
  output logic o_q // Synchronised level
);

  typedef struct packed {
    logic meta;
    logic q;
  } wpc_sync_t;

  wpc_sync_t s_r;
  wpc_sync_t s_nxt;

  always_comb
  begin
    s_nxt.meta = i_d;
    s_nxt.q = s_r.meta;
    if (!i_nrst)
    begin
      s_nxt.meta = RESET_VAL;
      s_nxt.q = RESET_VAL;
    end
  end

  always_ff @(posedge i_clk)
  begin
    s_r <= s_nxt;
  end

  assign o_q = s_r.q;

endmodule : wpc_sync

// *** hdl/wpc_top.sv ***
`timescale 1ns/100ps
module wpc_top
  import wpc_pkg::*;
#(
  parameter int NV_WRITE_CYC = NV_WRITE_CYCLES,
  parameter int TAP_W = 7
) (
  input wire logic i_clk, // Main clock
  input wire logic i_nrst, // Synchronous reset, active low
  input wire logic i_sck, // Serial clock from host
  input wire logic i_cs_n, // Chip select, active low
  input wire logic i_serial_in, // Serial data from host
  input wire logic i_power_down_n, // Shutdown pin, active low
  output logic o_serial_out, // Open-drain data level, always low
  output logic o_serial_out_oe_n, // Low while pulling the data line low
  output logic [TAP_W-1:0] o_tap, // Selected tap
  output logic o_array_open, // Resistor array disconnected
  output logic o_wiper_to_ground, // Wiper shorted to ground
  output logic o_nv_write_busy, // Stored write in progress
  output logic o_standby // Deselected and idle
);

  localparam int CNT_MAX = (NV_WRITE_CYC > RECALL_CYCLES) ? NV_WRITE_CYC : RECALL_CYCLES;
  localparam int CNT_W = $clog2(CNT_MAX + 1);

  typedef enum logic [1:0] {
    PH_POWER_UP = 2'b00,
    PH_RUN = 2'b01,
    PH_NV_WRITE = 2'b10
  } wpc_phase_t;

  // Link-side frame state, cleared whenever select is high
  typedef struct packed {
    logic [4:0] cnt;
    logic [7:0] id;
    logic [7:0] ins;
    logic [7:0] sh;
    logic [7:0] tx;
    logic rd_en;
    logic wr_ok;
  } wpc_link_t;

  // Write payload, held across select rise until the main side takes it
  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] data;
  } wpc_cap_t;

  // Main-side state
  typedef struct packed {
    wpc_phase_t phase;
    logic [CNT_W-1:0] cnt;
    logic [TAP_W-1:0] wiper;
    logic volatile_only_select;
    logic power_down_n_n;
    logic armed;
    logic frame_ok;
    logic pending;
    logic cs_d;
    logic [TAP_W-1:0] shadow_pos;
    logic [7:0] shadow_acr;
    logic shadow_armed;
    logic [TAP_W-1:0] tap;
    logic open;
    logic gnd;
    logic busy;
    logic standby;
  } wpc_main_t;

  localparam wpc_link_t LINK_RESET = '0;

  wpc_link_t ln_r;
  wpc_link_t ln_nxt;
  wpc_cap_t cap_r;
  wpc_cap_t cap_nxt;
  wpc_main_t cl_r;
  wpc_main_t cl_nxt;
  logic drive_low_r;
  logic drive_low_nxt;
  // Stands for the non-volatile cell: no reset, so it keeps its value across i_nrst
  logic [TAP_W-1:0] store_r = TAP_W'(STORE_INIT);
  logic [TAP_W-1:0] store_nxt;

  logic cs_s;
  logic pd_s;
  logic wr_ok_s;
  logic [7:0] shift_in;
  logic [2:0] tx_idx;
  logic cs_rise;
  logic cs_fall;
  logic commit;
  logic shutdown;

  // Link domain

  always_comb
  begin
    ln_nxt = ln_r;
    cap_nxt = cap_r;
    shift_in = {ln_r.sh[6:0], i_serial_in};
    ln_nxt.sh = shift_in;
    if (ln_r.cnt != BIT_LIMIT)
    begin
      ln_nxt.cnt = ln_r.cnt + 5'h01;
    end
    if (ln_r.cnt == BIT_ID_LAST)
    begin
      ln_nxt.id = shift_in;
    end
    if (ln_r.cnt == BIT_INSTR_LAST)
    begin
      ln_nxt.ins = shift_in;
      // Shadow copy is frozen by the main side while select is low
      if ((ln_r.id == ID_BYTE) && (shift_in[7:4] == INSTR_READ)
          && (shift_in[3:2] == 2'h0) && cl_r.shadow_armed)
      begin
        ln_nxt.rd_en = 1'h1;
        if (shift_in[1:0] == ADDR_POSITION)
        begin
          ln_nxt.tx = 8'({1'h0, cl_r.shadow_pos});
        end
        else if (shift_in[1:0] == ADDR_ACCESS)
        begin
          ln_nxt.tx = cl_r.shadow_acr;
        end
        else
        begin
          ln_nxt.tx = 8'h00;
        end
      end
    end
    if (ln_r.cnt == BIT_DATA_LAST)
    begin
      if ((ln_r.id == ID_BYTE) && (ln_r.ins[7:4] == INSTR_WRITE)
          && (ln_r.ins[3:2] == 2'h0))
      begin
        ln_nxt.wr_ok = 1'h1;
        cap_nxt.addr = ln_r.ins[1:0];
        cap_nxt.data = shift_in;
      end
    end
  end

  // Select high acts as the frame reset; the serial clock may stop outside frames
  always_ff @(posedge i_sck or posedge i_cs_n)
  begin
    if (i_cs_n)
    begin
      ln_r <= LINK_RESET;
    end
    else
    begin
      ln_r <= ln_nxt;
    end
  end

  always_ff @(posedge i_sck)
  begin
    cap_r <= cap_nxt;
  end

  always_comb
  begin
    tx_idx = 3'(BIT_DATA_LAST - ln_r.cnt);
    drive_low_nxt = 1'h0;
    if (ln_r.rd_en && (ln_r.cnt >= BIT_DATA_FIRST) && (ln_r.cnt < BIT_FRAME_END))
    begin
      drive_low_nxt = ~ln_r.tx[tx_idx];
    end
  end

  always_ff @(negedge i_sck or posedge i_cs_n)
  begin
    if (i_cs_n)
    begin
      drive_low_r <= 1'h0;
    end
    else
    begin
      drive_low_r <= drive_low_nxt;
    end
  end

  assign o_serial_out = 1'h0;
  assign o_serial_out_oe_n = ~drive_low_r;

  // Crossings into the main domain

  wpc_sync #(
    .RESET_VAL(1'h0)
  ) u_sync_cs (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_d(i_cs_n),
    .o_q(cs_s)
  );

  wpc_sync #(
    .RESET_VAL(1'h1)
  ) u_sync_pd (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_d(i_power_down_n),
    .o_q(pd_s)
  );

  wpc_sync #(
    .RESET_VAL(1'h0)
  ) u_sync_wr (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_d(ln_r.wr_ok),
    .o_q(wr_ok_s)
  );

  // Main domain

  assign cs_rise = cs_s & ~cl_r.cs_d;
  assign cs_fall = ~cs_s & cl_r.cs_d;
  // Writes wait for select to rise, so the stored write starts after the frame
  assign commit = cs_rise & cl_r.pending & cl_r.frame_ok & (cl_r.phase == PH_RUN);
  assign shutdown = ~pd_s | ~cl_r.power_down_n_n;

  always_comb
  begin
    cl_nxt = cl_r;
    store_nxt = store_r;
    cl_nxt.cs_d = cs_s;
    if (cs_s)
    begin
      cl_nxt.armed = 1'h1;
    end
    if (cs_fall)
    begin
      cl_nxt.frame_ok = cl_r.armed;
    end
    if (cs_rise)
    begin
      cl_nxt.pending = 1'h0;
    end
    // Only taken while select is low, so a late copy cannot replay the write
    if (wr_ok_s && !cs_s)
    begin
      cl_nxt.pending = 1'h1;
    end

    case (cl_r.phase)
      PH_POWER_UP:
      begin
        cl_nxt.cnt = cl_r.cnt + CNT_W'(1);
        if (cl_r.cnt == CNT_W'(RECALL_CYCLES - 1))
        begin
          cl_nxt.wiper = store_r;
          cl_nxt.phase = PH_RUN;
          cl_nxt.cnt = '0;
        end
      end
      PH_NV_WRITE:
      begin
        cl_nxt.cnt = cl_r.cnt + CNT_W'(1);
        if (cl_r.cnt == CNT_W'(NV_WRITE_CYC - 1))
        begin
          cl_nxt.phase = PH_RUN;
          cl_nxt.cnt = '0;
        end
      end
      default:
      begin
        cl_nxt.cnt = '0;
        if (commit)
        begin
          if (cap_r.addr == ADDR_POSITION)
          begin
            if (cl_r.volatile_only_select)
            begin
              cl_nxt.wiper = cap_r.data[TAP_W-1:0];
            end
            else
            begin
              store_nxt = cap_r.data[TAP_W-1:0];
              cl_nxt.wiper = cap_r.data[TAP_W-1:0];
              cl_nxt.phase = PH_NV_WRITE;
            end
          end
          else if (cap_r.addr == ADDR_ACCESS)
          begin
            cl_nxt.volatile_only_select = cap_r.data[ACR_VOL_BIT];
            cl_nxt.power_down_n_n = cap_r.data[ACR_POWER_DOWN_N_BIT];
          end
          // Reserved and unused addresses change nothing
        end
      end
    endcase

    // Read image only moves between frames, so the link side sees a steady word
    if (cs_s)
    begin
      cl_nxt.shadow_pos = cl_r.volatile_only_select ? cl_r.wiper : store_r;
      cl_nxt.shadow_acr = 8'h00;
      cl_nxt.shadow_acr[ACR_VOL_BIT] = cl_r.volatile_only_select;
      cl_nxt.shadow_acr[ACR_POWER_DOWN_N_BIT] = cl_r.power_down_n_n;
      cl_nxt.shadow_acr[ACR_BUSY_BIT] = (cl_r.phase == PH_NV_WRITE);
      cl_nxt.shadow_armed = cl_r.armed;
    end

    cl_nxt.tap = cl_r.wiper;
    // Wiper register is untouched in shutdown, so release restores the old tap
    cl_nxt.open = shutdown;
    cl_nxt.gnd = shutdown;
    cl_nxt.busy = (cl_r.phase == PH_NV_WRITE);
    cl_nxt.standby = cs_s & (cl_r.phase != PH_NV_WRITE);

    if (!i_nrst)
    begin
      cl_nxt = '0;
      cl_nxt.phase = PH_POWER_UP;
      cl_nxt.wiper = TAP_W'(WIPER_RESET);
      cl_nxt.tap = TAP_W'(WIPER_RESET);
      cl_nxt.volatile_only_select = VOL_RESET;
      cl_nxt.power_down_n_n = POWER_DOWN_N_N_RESET;
      store_nxt = store_r;
    end
  end

  always_ff @(posedge i_clk)
  begin
    cl_r <= cl_nxt;
    store_r <= store_nxt;
  end

  assign o_tap = cl_r.tap;
  assign o_array_open = cl_r.open;
  assign o_wiper_to_ground = cl_r.gnd;
  assign o_nv_write_busy = cl_r.busy;
  assign o_standby = cl_r.standby;

endmodule : wpc_top

// *** pkg/wpc_pkg.sv ***
package wpc_pkg;

  // Main clock
  localparam int CLK_PERIOD_NS = 10;

  // Self-timed non-volatile write, longest time, rounds down
  localparam int NV_WRITE_TIME_MS = 20;
  localparam int NV_WRITE_CYCLES = (NV_WRITE_TIME_MS * 1000000) / CLK_PERIOD_NS;

  // Settling time before the stored position is trusted, least time, rounds up
  localparam int RECALL_DELAY_NS = 1000;
  localparam int RECALL_CYCLES = (RECALL_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Serial frame layout
  localparam logic [7:0] ID_BYTE = 8'h50;
  localparam logic [3:0] INSTR_READ = 4'hB;
  localparam logic [3:0] INSTR_WRITE = 4'hC;
  localparam logic [4:0] BIT_ID_LAST = 5'h07;
  localparam logic [4:0] BIT_INSTR_LAST = 5'h0F;
  localparam logic [4:0] BIT_DATA_FIRST = 5'h10;
  localparam logic [4:0] BIT_DATA_LAST = 5'h17;
  localparam logic [4:0] BIT_FRAME_END = 5'h18;
  localparam logic [4:0] BIT_LIMIT = 5'h1F;

  // Register addresses
  localparam logic [1:0] ADDR_POSITION = 2'h0;
  localparam logic [1:0] ADDR_RESERVED = 2'h1;
  localparam logic [1:0] ADDR_ACCESS = 2'h2;

  // Access control fields
  localparam int ACR_VOL_BIT = 7;
  localparam int ACR_POWER_DOWN_N_BIT = 6;
  localparam int ACR_BUSY_BIT = 5;

  // Values after reset, and the stored position at start-up
  localparam logic [6:0] WIPER_RESET = 7'h40;
  localparam logic VOL_RESET = 1'h0;
  localparam logic POWER_DOWN_N_N_RESET = 1'h1;
  localparam logic [6:0] STORE_INIT = 7'h40;

endpackage : wpc_pkg

// *** sim/tb.sv ***
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module tb
  import wpc_pkg::*;
;
  localparam int NVC = 3000;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic pd_n = 1'b1;
  logic sck, cs_n, mosi, serial_out, oe_n, opn, gnd, busy, stby;
  logic [6:0] tap;
  logic [7:0] rd;
  int failures = 0;
  int n_checks = 0;
  wire line = oe_n ? 1'b1 : serial_out;
  always #5 i_clk = ~i_clk;
  wpc_top #(.NV_WRITE_CYC(NVC)) dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_sck(sck),
    .i_cs_n(cs_n), .i_serial_in(mosi), .i_power_down_n(pd_n), .o_serial_out(serial_out),
    .o_serial_out_oe_n(oe_n), .o_tap(tap), .o_array_open(opn), .o_wiper_to_ground(gnd),
    .o_nv_write_busy(busy), .o_standby(stby));
  wpc_host host (.o_sck(sck), .o_cs_n(cs_n), .o_mosi(mosi), .i_miso(line));
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask : cyc
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    host.frame({ID_BYTE, INSTR_WRITE, 2'h0, a, d}, 24, rd);
  endtask : wr
  task automatic rdv(input logic [1:0] a, input logic [7:0] e);
    host.frame({ID_BYTE, INSTR_READ, 2'h0, a, 8'h00}, 24, rd);
    `CHK(rd, e)
  endtask : rdv
  task automatic rst();
    cyc(1);
    i_nrst = 1'b0;
    cyc(3);
    i_nrst = 1'b1;
  endtask : rst
  task automatic end_sim();
    if (failures == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim
  initial
  begin
    logic [7:0] codes [3] = '{8'h00, 8'h7F, 8'h2A};
    int k;
    rst();
    cyc(120);
    `CHK(tap, 7'h40)
    rdv(ADDR_ACCESS, 8'h40);
    wr(ADDR_RESERVED, 8'hFF);
    rdv(ADDR_RESERVED, 8'h00);
    rdv(ADDR_ACCESS, 8'h40);
    wr(ADDR_ACCESS, 8'hFF);
    rdv(ADDR_ACCESS, 8'hC0);
    for (k = 0; k < 3; k++)
    begin
      wr(ADDR_POSITION, codes[k]);
      `CHK(tap, codes[k][6:0])
      rdv(ADDR_POSITION, codes[k]);
    end
    host.frame({8'h51, INSTR_WRITE, 4'h0, 8'h11}, 24, rd);
    host.frame({ID_BYTE, 8'hD0, 8'h11}, 24, rd);
    host.frame({ID_BYTE, 8'hC4, 8'h11}, 24, rd);
    host.frame({ID_BYTE, 8'hC0, 8'h11}, 20, rd);
    `CHK(tap, 7'h2A)
    wr(ADDR_ACCESS, 8'h80);
    `CHK({opn, gnd, tap}, {2'b11, 7'h2A})
    rdv(ADDR_ACCESS, 8'h80);
    cyc(1);
    pd_n = 1'b0;
    wr(ADDR_ACCESS, 8'hC0);
    `CHK({opn, gnd}, 2'b11)
    rdv(ADDR_ACCESS, 8'hC0);
    rdv(ADDR_POSITION, 8'h2A);
    cyc(1);
    pd_n = 1'b1;
    cyc(5);
    `CHK({opn, gnd, tap}, {2'b00, 7'h2A})
    wr(ADDR_ACCESS, 8'h40);
    wr(ADDR_POSITION, 8'h33);
    `CHK({busy, stby, tap}, {2'b10, 7'h33})
    rdv(ADDR_ACCESS, 8'h60);
    wr(ADDR_ACCESS, 8'hC0);
    wr(ADDR_POSITION, 8'h01);
    `CHK(tap, 7'h33)
    for (k = 0; k < 4000 && busy !== 1'b0; k++)
      cyc(1);
    cyc(2);
    `CHK({busy, stby}, 2'b01)
    if (busy !== 1'b0)
      end_sim();
    rdv(ADDR_ACCESS, 8'h40);
    rdv(ADDR_POSITION, 8'h33);
    rst();
    `CHK(tap, 7'h40)
    cyc(120);
    `CHK(tap, 7'h33)
    end_sim();
  end
endmodule : tb
bind wpc_top wpc_monitor #(.NV_WRITE_CYC(NV_WRITE_CYC)) mon (.i_clk(i_clk), .i_nrst(i_nrst),
  .i_sck(i_sck), .i_cs_n(i_cs_n), .i_serial_in(i_serial_in), .i_power_down_n(i_power_down_n),
  .o_serial_out(o_serial_out), .o_serial_out_oe_n(o_serial_out_oe_n), .o_tap(o_tap),
  .o_array_open(o_array_open), .o_wiper_to_ground(o_wiper_to_ground),
  .o_nv_write_busy(o_nv_write_busy), .o_standby(o_standby));

// *** sim/wpc_host.sv ***
`timescale 1ns/100ps
module wpc_host (
  output logic o_sck, // Link clock, idle low
  output logic o_cs_n, // Select
  output logic o_mosi, // Host data
  input wire logic i_miso // Resolved data line
);
  initial
  begin
    o_sck = 1'b0;
    o_cs_n = 1'b0;
    o_mosi = 1'b0;
    // A clean rise clears the device's link state before the first frame
    #1 o_cs_n = 1'b1;
  end
  // Clock stands still outside frames; each 24-bit frame shifts the next one's edges by 7 ns, so some land on main clock edges
  task automatic frame(input logic [23:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    #37 o_cs_n = 1'b0;
    for (int i = 23; i > 23 - nbits; i--)
    begin
      o_mosi = tx[i];
      #80 o_sck = 1'b1;
      if (i < 8)
        rx = {rx[6:0], i_miso};
      #80 o_sck = 1'b0;
    end
    o_mosi = ~o_mosi;
    #80 o_cs_n = 1'b1;
    #2000;
  endtask : frame
endmodule : wpc_host

// *** sim/wpc_monitor.sv ***
`timescale 1ns/100ps
module wpc_monitor #(
  parameter int NV_WRITE_CYC = 50
) (
  input wire logic i_clk, // Clock
  input wire logic i_nrst, // Reset
  input wire logic i_sck, // Link clock
  input wire logic i_cs_n, // Select
  input wire logic i_serial_in, // Host data
  input wire logic i_power_down_n, // Shutdown pin
  input wire logic o_serial_out, // Data level
  input wire logic o_serial_out_oe_n, // Data enable
  input wire logic [6:0] o_tap, // Tap
  input wire logic o_array_open, // Array open
  input wire logic o_wiper_to_ground, // Wiper grounded
  input wire logic o_nv_write_busy, // Busy
  input wire logic o_standby // Standby
);
  int busy_cnt_r;
  always_ff @(posedge i_clk)
  begin
    busy_cnt_r <= (!i_nrst || !o_nv_write_busy) ? 0 : busy_cnt_r + 1;
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);
  property p_idle_release;
    i_cs_n && $past(i_cs_n) |-> o_serial_out_oe_n;
  endproperty
  a_idle_release: assert property (p_idle_release) else $error("line not released");
  property p_standby_busy;
    o_standby |-> !o_nv_write_busy;
  endproperty
  a_standby_busy: assert property (p_standby_busy) else $error("standby while busy");
  property p_select_wakes;
    (!i_cs_n) [*6] |=> !o_standby;
  endproperty
  a_select_wakes: assert property (p_select_wakes) else $error("standby while selected");
  property p_shut_pair;
    o_array_open == o_wiper_to_ground;
  endproperty
  a_shut_pair: assert property (p_shut_pair) else $error("shutdown outputs differ");
  property p_pin_shut;
    (!i_power_down_n) [*4] |=> o_array_open;
  endproperty
  a_pin_shut: assert property (p_pin_shut) else $error("pin shutdown missed");
  property p_nv_start;
    $rose(o_nv_write_busy) |-> i_cs_n && $past(i_cs_n, 3);
  endproperty
  a_nv_start: assert property (p_nv_start) else $error("busy before select rise");
  property p_nv_len;
    $fell(o_nv_write_busy) |-> busy_cnt_r inside {[NV_WRITE_CYC-1:NV_WRITE_CYC]};
  endproperty
  a_nv_len: assert property (p_nv_len) else $error("stored write length wrong");
  property p_reset_mid;
    $rose(i_nrst) |-> (o_tap == 7'h40) [*8];
  endproperty
  a_reset_mid: assert property (p_reset_mid) else $error("tap not mid-scale");
endmodule : wpc_monitor
